// file: rtl/esa_defs.svh
// Offsets, field positions, reset values and timing figures of the eight-port serial adapter.
`ifndef ESA_DEFS_SVH
`define ESA_DEFS_SVH

// ----------------------------------------------------------------
// Bus map (byte addresses)
// ----------------------------------------------------------------
`define ESA_OFF_ARB      9'h130
`define ESA_OFF_IRQ_STAT 9'h134
`define ESA_OFF_IRQ_MASK 9'h138
`define ESA_BANK_BIT     8

// ----------------------------------------------------------------
// Per-channel register indices
// ----------------------------------------------------------------
`define ESA_REG_DATA 3'h0
`define ESA_REG_IEN  3'h1
`define ESA_REG_IID  3'h2
`define ESA_REG_LCTL 3'h3
`define ESA_REG_MCTL 3'h4
`define ESA_REG_LST  3'h5
`define ESA_REG_MST  3'h6
`define ESA_REG_SCR  3'h7

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ESA_LCTL_PEN   3
`define ESA_LCTL_EVEN  4
`define ESA_LCTL_BRK   6
`define ESA_LCTL_DLAB  7
`define ESA_LCTL_RST   8'h03
`define ESA_DIV_RST    16'h0001
`define ESA_ID_LS      4'h6
`define ESA_ID_RD      4'h4
`define ESA_ID_TH      4'h2
`define ESA_ID_MS      4'h0
`define ESA_ID_NONE    4'h1
`define ESA_ADAPTER_ID 3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ESA_CLK_KHZ    250000
`define ESA_REF_KHZ    12288
`define ESA_OVERSAMPLE 16
`define ESA_FIFO_DEPTH 16

`endif

// file: rtl/esa_pkg.sv
// Types shared by the eight-port serial adapter.
package esa_pkg;

  typedef enum logic [2:0] {
    ESA_IDLE  = 3'b000,
    ESA_START = 3'b001,
    ESA_DATA  = 3'b011,
    ESA_PAR   = 3'b010,
    ESA_STOP  = 3'b110
  } esa_bit_e;

  typedef struct packed {
    logic rx;
    logic cts;
    logic dsr;
    logic ri;
    logic dcd;
  } esa_line_in_s;

  typedef struct packed {
    logic tx;
    logic rts;
    logic dtr;
  } esa_line_out_s;

endpackage

// file: rtl/esa_adapter.sv
// Eight-channel asynchronous serial adapter with a classic Wishbone register slave.
`timescale 1ns/1ps
`include "esa_defs.svh"

module esa_channel
  import esa_pkg::*;
#(
  parameter int FIFO_DEPTH = `ESA_FIFO_DEPTH
) (
  input  wire logic          clk_sys_in,
  input  wire logic          rst_b_in,
  input  wire logic          ref_tick_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  input  wire logic [2:0]    reg_addr_in,
  input  wire logic [7:0]    reg_wdata_in,
  input  wire esa_line_in_s  pins_in,
  output logic [7:0]         reg_rdata_out,
  output esa_line_out_s      pins_out,
  output logic               int_pend_out,
  output logic [3:0]         int_id_out
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [PW:0] DEPTH_N = (PW+1)'(FIFO_DEPTH);

  function automatic logic par_of(input logic [7:0] d, input logic [1:0] wl, input logic even);
    logic [7:0] m;
    m = d & (8'hff >> (3'h3 - {1'b0, wl}));
    return even ? ^m : ~^m;
  endfunction

  logic [7:0]    lctl_q, scr_q, dll_q, dlm_q;
  logic [3:0]    ien_q;
  logic [1:0]    mctl_q;
  logic          fifo_en_q;
  logic [1:0]    trig_q;
  logic [7:0]    tx_mem [FIFO_DEPTH];
  logic [7:0]    rx_mem [FIFO_DEPTH];
  logic [PW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [PW:0]   tx_cnt_q, rx_cnt_q, lim;
  logic [15:0]   baud_cnt_q;
  logic          os_tick;
  esa_bit_e      tx_st_q, rx_st_q;
  logic [4:0]    tx_ph_q, rx_ph_q, tx_lim;
  logic [2:0]    tx_bit_q, rx_bit_q;
  logic [7:0]    tx_sh_q, rx_sh_q, brk_cnt_q, frame_ticks;
  logic          tx_line_q, tx_pop, rx_push, rx_perr_q;
  logic          oe_q, pe_q, fe_q, bi_q, thre_q, tx_empty_q, brk_seen_q;
  logic [3:0]    ms_q, msd_q;
  logic          dlab, wr_data, rd_data, rd_lst, rd_mst, rd_iid, tx_rst, rx_rst;
  logic          ls_int, rd_int, th_int, ms_int;
  logic [PW:0]   trig_n;

  assign dlab    = lctl_q[`ESA_LCTL_DLAB];
  assign wr_data = reg_wr_in && reg_addr_in == `ESA_REG_DATA && !dlab;
  assign rd_data = reg_rd_in && reg_addr_in == `ESA_REG_DATA && !dlab;
  assign rd_lst  = reg_rd_in && reg_addr_in == `ESA_REG_LST;
  assign rd_mst  = reg_rd_in && reg_addr_in == `ESA_REG_MST;
  assign rd_iid  = reg_rd_in && reg_addr_in == `ESA_REG_IID;
  assign tx_rst  = reg_wr_in && reg_addr_in == `ESA_REG_IID && reg_wdata_in[2];
  assign rx_rst  = reg_wr_in && reg_addr_in == `ESA_REG_IID && reg_wdata_in[1];
  assign lim     = fifo_en_q ? DEPTH_N : (PW+1)'(1);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      lctl_q    <= `ESA_LCTL_RST;
      ien_q     <= 4'h0;
      mctl_q    <= 2'h0;
      scr_q     <= 8'h00;
      dll_q     <= 8'(`ESA_DIV_RST);
      dlm_q     <= 8'(`ESA_DIV_RST >> 8);
      fifo_en_q <= 1'b0;
      trig_q    <= 2'h0;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        `ESA_REG_DATA: if (dlab) dll_q <= reg_wdata_in;
        `ESA_REG_IEN: begin
          if (dlab) dlm_q <= reg_wdata_in;
          else ien_q <= reg_wdata_in[3:0];
        end
        `ESA_REG_IID: begin
          fifo_en_q <= reg_wdata_in[0];
          trig_q    <= reg_wdata_in[7:6];
        end
        `ESA_REG_LCTL: lctl_q <= reg_wdata_in;
        `ESA_REG_MCTL: mctl_q <= reg_wdata_in[1:0];
        `ESA_REG_SCR:  scr_q <= reg_wdata_in;
        `ESA_REG_LST, `ESA_REG_MST: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Baud divider: sixteen sample ticks per bit from the reference tick
  // ----------------------------------------------------------------
  assign os_tick = ref_tick_in && (baud_cnt_q + 16'h0001 >= {dlm_q, dll_q});

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) baud_cnt_q <= 16'h0000;
    else if (os_tick) baud_cnt_q <= 16'h0000;
    else if (ref_tick_in) baud_cnt_q <= baud_cnt_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Transmit buffer and serialiser
  // ----------------------------------------------------------------
  assign tx_pop = tx_st_q == ESA_IDLE && tx_cnt_q != '0;
  // A character written while the buffer is full is dropped, as on a classic part.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || tx_rst) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (wr_data && tx_cnt_q < lim) begin
        tx_mem[tx_wp_q] <= reg_wdata_in;
        tx_wp_q         <= tx_wp_q + 1'b1;
      end
      if (tx_pop) tx_rp_q <= tx_rp_q + 1'b1;
      tx_cnt_q <= tx_cnt_q + (PW+1)'(wr_data && tx_cnt_q < lim) - (PW+1)'(tx_pop);
    end
  end

  always_comb begin
    if (tx_st_q != ESA_STOP || !lctl_q[2]) tx_lim = 5'd15;
    else if (lctl_q[1:0] == 2'b00) tx_lim = 5'd23;
    else tx_lim = 5'd31;
  end

  // The serialiser runs on its own state so a receive never holds it back.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      tx_st_q   <= ESA_IDLE;
      tx_line_q <= 1'b1;
      tx_ph_q   <= 5'd0;
      tx_bit_q  <= 3'd0;
      tx_sh_q   <= 8'h00;
    end else if (tx_pop) begin
      tx_st_q   <= ESA_START;
      tx_line_q <= 1'b0;
      tx_ph_q   <= 5'd0;
      tx_bit_q  <= 3'd0;
      tx_sh_q   <= tx_mem[tx_rp_q];
    end else if (os_tick && tx_st_q != ESA_IDLE) begin
      tx_ph_q <= tx_ph_q + 5'd1;
      if (tx_ph_q == tx_lim) begin
        tx_ph_q <= 5'd0;
        unique case (tx_st_q)
          ESA_START: begin
            tx_st_q   <= ESA_DATA;
            tx_line_q <= tx_sh_q[0];
          end
          ESA_DATA: begin
            tx_bit_q <= tx_bit_q + 3'd1;
            if (tx_bit_q == {1'b1, lctl_q[1:0]}) begin
              tx_st_q   <= lctl_q[`ESA_LCTL_PEN] ? ESA_PAR : ESA_STOP;
              tx_line_q <= lctl_q[`ESA_LCTL_PEN] ? par_of(tx_sh_q,
                           lctl_q[1:0], lctl_q[`ESA_LCTL_EVEN]) : 1'b1;
            end else tx_line_q <= tx_sh_q[tx_bit_q + 3'd1];
          end
          ESA_PAR: begin
            tx_st_q   <= ESA_STOP;
            tx_line_q <= 1'b1;
          end
          ESA_STOP: tx_st_q <= ESA_IDLE;
          default:  tx_st_q <= ESA_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver: restarts on each start edge and samples mid-bit
  // ----------------------------------------------------------------
  assign rx_push = os_tick && rx_st_q == ESA_STOP && rx_ph_q == 5'd15;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rx_st_q   <= ESA_IDLE;
      rx_ph_q   <= 5'd0;
      rx_bit_q  <= 3'd0;
      rx_sh_q   <= 8'h00;
      rx_perr_q <= 1'b0;
    end else if (rx_st_q == ESA_IDLE) begin
      if (!pins_in.rx) begin
        rx_st_q <= ESA_START;
        rx_ph_q <= 5'd0;
      end
    end else if (os_tick) begin
      rx_ph_q <= rx_ph_q + 5'd1;
      unique case (rx_st_q)
        ESA_START: if (rx_ph_q == 5'd7) begin
          rx_st_q   <= pins_in.rx ? ESA_IDLE : ESA_DATA;
          rx_ph_q   <= 5'd0;
          rx_bit_q  <= 3'd0;
          rx_sh_q   <= 8'h00;
          rx_perr_q <= 1'b0;
        end
        ESA_DATA: if (rx_ph_q == 5'd15) begin
          rx_ph_q           <= 5'd0;
          rx_sh_q[rx_bit_q] <= pins_in.rx;
          rx_bit_q          <= rx_bit_q + 3'd1;
          if (rx_bit_q == {1'b1, lctl_q[1:0]})
            rx_st_q <= lctl_q[`ESA_LCTL_PEN] ? ESA_PAR : ESA_STOP;
        end
        ESA_PAR: if (rx_ph_q == 5'd15) begin
          rx_ph_q   <= 5'd0;
          rx_st_q   <= ESA_STOP;
          rx_perr_q <= pins_in.rx != par_of(rx_sh_q, lctl_q[1:0], lctl_q[`ESA_LCTL_EVEN]);
        end
        ESA_STOP: if (rx_ph_q == 5'd15) rx_st_q <= ESA_IDLE;
        default:  rx_st_q <= ESA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || rx_rst) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push && rx_cnt_q < lim) begin
        rx_mem[rx_wp_q] <= rx_sh_q;
        rx_wp_q         <= rx_wp_q + 1'b1;
      end
      if (rd_data && rx_cnt_q != '0) rx_rp_q <= rx_rp_q + 1'b1;
      rx_cnt_q <= rx_cnt_q + (PW+1)'(rx_push && rx_cnt_q < lim) - (PW+1)'(rd_data && rx_cnt_q != '0);
    end
  end

  // Break needs the line low for longer than a whole frame of the current format.
  assign frame_ticks = 8'({4'd7 + {2'b00, lctl_q[1:0]} + {3'b000, lctl_q[`ESA_LCTL_PEN]}
                       + {3'b000, lctl_q[2]}, 4'h0});

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || pins_in.rx) begin
      brk_cnt_q  <= 8'h00;
      brk_seen_q <= 1'b0;
    end else if (os_tick && !brk_seen_q) begin
      brk_cnt_q <= brk_cnt_q + 8'h01;
      if (brk_cnt_q > frame_ticks) brk_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Line status: set wins over the clear by a status read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      {oe_q, pe_q, fe_q, bi_q} <= 4'h0;
    end else begin
      if (rd_lst) {oe_q, pe_q, fe_q, bi_q} <= 4'h0;
      if (rx_push && rx_cnt_q >= lim) oe_q <= 1'b1;
      if (rx_push && rx_perr_q && lctl_q[`ESA_LCTL_PEN]) pe_q <= 1'b1;
      if (rx_push && !pins_in.rx) fe_q <= 1'b1;
      if (os_tick && !pins_in.rx && !brk_seen_q && brk_cnt_q > frame_ticks) bi_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      tx_empty_q <= 1'b1;
      thre_q     <= 1'b0;
    end else begin
      tx_empty_q <= tx_cnt_q == '0;
      if (wr_data || (rd_iid && int_id_out == `ESA_ID_TH)) thre_q <= 1'b0;
      if ((tx_cnt_q == '0 && !tx_empty_q) ||
          (reg_wr_in && reg_addr_in == `ESA_REG_IEN && !dlab && reg_wdata_in[1] && !ien_q[1] && tx_cnt_q == '0))
        thre_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      // Matches the pin filter's reset level, so leaving reset is not seen as a change.
      ms_q  <= 4'hf;
      msd_q <= 4'h0;
    end else begin
      ms_q <= {pins_in.dcd, pins_in.ri, pins_in.dsr, pins_in.cts};
      if (rd_mst) msd_q <= 4'h0;
      if (pins_in.cts != ms_q[0]) msd_q[0] <= 1'b1;
      if (pins_in.dsr != ms_q[1]) msd_q[1] <= 1'b1;
      if (!pins_in.ri && ms_q[2]) msd_q[2] <= 1'b1;
      if (pins_in.dcd != ms_q[3]) msd_q[3] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt identification, highest source first
  // ----------------------------------------------------------------
  always_comb begin
    unique case (trig_q)
      2'b00: trig_n = (PW+1)'(1);
      2'b01: trig_n = (PW+1)'(4);
      2'b10: trig_n = (PW+1)'(8);
      2'b11: trig_n = (PW+1)'(14);
    endcase
  end

  assign ls_int = ien_q[2] && (oe_q || pe_q || fe_q || bi_q);
  assign rd_int = ien_q[0] && (fifo_en_q ? rx_cnt_q >= trig_n : rx_cnt_q != '0);
  assign th_int = ien_q[1] && thre_q;
  assign ms_int = ien_q[3] && msd_q != 4'h0;

  always_comb begin
    if (ls_int) int_id_out = `ESA_ID_LS;
    else if (rd_int) int_id_out = `ESA_ID_RD;
    else if (th_int) int_id_out = `ESA_ID_TH;
    else if (ms_int) int_id_out = `ESA_ID_MS;
    else int_id_out = `ESA_ID_NONE;
  end
  assign int_pend_out = !int_id_out[0];

  always_comb begin
    unique case (reg_addr_in)
      `ESA_REG_DATA: reg_rdata_out = dlab ? dll_q : rx_mem[rx_rp_q];
      `ESA_REG_IEN:  reg_rdata_out = dlab ? dlm_q : {4'h0, ien_q};
      `ESA_REG_IID:  reg_rdata_out = {{2{fifo_en_q}}, 2'b00, int_id_out};
      `ESA_REG_LCTL: reg_rdata_out = lctl_q;
      `ESA_REG_MCTL: reg_rdata_out = {6'h00, mctl_q};
      `ESA_REG_LST:  reg_rdata_out = {1'b0, tx_empty_q && tx_st_q == ESA_IDLE, tx_cnt_q == '0,
                                      bi_q, fe_q, pe_q, oe_q, rx_cnt_q != '0};
      `ESA_REG_MST:  reg_rdata_out = {ms_q[3], ms_q[2], ms_q[1], ms_q[0], msd_q};
      `ESA_REG_SCR:  reg_rdata_out = scr_q;
    endcase
  end

  assign pins_out.tx  = tx_line_q && !lctl_q[`ESA_LCTL_BRK];
  assign pins_out.rts = mctl_q[1];
  assign pins_out.dtr = mctl_q[0];
endmodule

// ----------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------
// Overview of operation
// - Each channel frames five to eight data bits, chosen by software.
// - One, one and a half, or two stop bits per sent character.
// - Parity even, odd or none, generated on send and checked on receive.
// - A parity error is flagged only while parity is enabled.
// - Start bit, data, optional parity, stop bits; receiver realigns per start bit.
// - With buffering on, send and receive each hold sixteen characters.
// - Bit timing comes from a 12.288 MHz reference through a divider.
// - The divider spans about 11.7 bit/s (divisor 65535) up to 768,000 bit/s (divisor 1).
// - Send and receive run at once, neither stalls the other.
// - Host reaches channel registers by 3-bit index and 8-bit data.
// - Separately enabled data, holding-empty, line-status and modem-status interrupts.
// - A channel reports its highest pending interrupt source first.
// - Eight single-channel instances make eight ports numbered 0 to 7.
// - Pending ports are ranked fixed: port 0 highest, port 7 lowest.
// - Twelve software registers per channel for setup, data and status.
// - One 16-bit read at 0x130 names adapter, port and interrupt type.
// - The shared request line is pulled low while an unmasked port's sticky status bit is set.
module esa_adapter
  import esa_pkg::*;
#(
  parameter int FIFO_DEPTH = `ESA_FIFO_DEPTH
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_b_in,
  input  wire logic                wb_cyc_in,
  input  wire logic                wb_stb_in,
  input  wire logic                wb_we_in,
  input  wire logic [8:0]          wb_adr_in,
  input  wire logic [3:0]          wb_sel_in,
  input  wire logic [31:0]         wb_dat_in,
  input  wire esa_line_in_s [7:0]  ser_pins_in,
  output logic [31:0]              wb_dat_out,
  output logic                     wb_ack_out,
  output esa_line_out_s [7:0]      ser_pins_out,
  output logic                     irq_out,
  output logic                     irq_pin_out,
  output logic                     irq_oe_b_out
);
  localparam logic [17:0] REF_INC = 18'(`ESA_REF_KHZ);
  localparam logic [17:0] CLK_MOD = 18'(`ESA_CLK_KHZ);

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad
    $error("FIFO_DEPTH must be a power of two between 2 and 256");
  end

  function automatic logic [3:0] first_pending(input logic [7:0] p);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) if (p[i]) r = {1'b0, 3'(i)};
    return r;
  endfunction

  esa_line_in_s [7:0]  sync1_q, sync2_q, sync3_q, filt_q;
  esa_line_out_s [7:0] ch_out;
  logic [7:0]          ch_rdata [8];
  logic [3:0]          ch_id [8];
  logic [7:0]          ch_pend, ist_q, imsk_q;
  logic [17:0]         phase_q;
  logic [18:0]         phase_sum;
  logic                ref_tick_q, req, wr_ok;
  logic [3:0]          win;
  logic [15:0]         arb_word;

  // ----------------------------------------------------------------
  // Reference tick: 12.288 MHz average rate from the system clock
  // ----------------------------------------------------------------
  // One bit of headroom: just below the wrap point the sum leaves the 18-bit range.
  assign phase_sum = {1'b0, phase_q} + {1'b0, REF_INC};

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      phase_q    <= 18'h00000;
      ref_tick_q <= 1'b0;
    end else begin
      ref_tick_q <= phase_sum >= {1'b0, CLK_MOD};
      phase_q    <= phase_sum >= {1'b0, CLK_MOD} ? 18'(phase_sum - {1'b0, CLK_MOD}) : phase_sum[17:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      filt_q  <= '1;
    end else begin
      sync1_q <= ser_pins_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < 8; i++) if (sync2_q[i] == sync3_q[i]) filt_q[i] <= sync3_q[i];
    end
  end

  // ----------------------------------------------------------------
  // Channels: eight single-channel instances, eight ports
  // ----------------------------------------------------------------
  assign req   = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_ok = req && wb_we_in && wb_sel_in[0];

  for (genvar c = 0; c < 8; c++) begin : g_ch
    esa_channel #(.FIFO_DEPTH(FIFO_DEPTH)) u_ch (
      .clk_sys_in    (clk_sys_in),
      .rst_b_in      (rst_b_in),
      .ref_tick_in   (ref_tick_q),
      .reg_wr_in     (wr_ok && !wb_adr_in[`ESA_BANK_BIT] && wb_adr_in[7:5] == 3'(c)),
      .reg_rd_in     (req && !wb_we_in && !wb_adr_in[`ESA_BANK_BIT] && wb_adr_in[7:5] == 3'(c)),
      .reg_addr_in   (wb_adr_in[4:2]),
      .reg_wdata_in  (wb_dat_in[7:0]),
      .pins_in       (filt_q[c]),
      .reg_rdata_out (ch_rdata[c]),
      .pins_out      (ch_out[c]),
      .int_pend_out  (ch_pend[c]),
      .int_id_out    (ch_id[c])
    );
  end

  assign win      = first_pending(ch_pend);
  assign arb_word = {!win[3], 4'h0, `ESA_ADAPTER_ID, win[3] ? `ESA_ID_NONE : ch_id[win[2:0]],
                     1'b0, win[2:0]};

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= req;
      if (req && !wb_we_in) begin
        if (!wb_adr_in[`ESA_BANK_BIT]) wb_dat_out <= {24'h000000, ch_rdata[wb_adr_in[7:5]]};
        else if (wb_adr_in == `ESA_OFF_ARB) wb_dat_out <= {16'h0000, arb_word};
        else if (wb_adr_in == `ESA_OFF_IRQ_STAT) wb_dat_out <= {24'h000000, ist_q};
        else if (wb_adr_in == `ESA_OFF_IRQ_MASK) wb_dat_out <= {24'h000000, imsk_q};
        else wb_dat_out <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // System interrupt: sticky per-port status, mask, open-drain line
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      ist_q  <= 8'h00;
      imsk_q <= 8'h00;
    end else begin
      if (wr_ok && wb_adr_in == `ESA_OFF_IRQ_MASK) imsk_q <= wb_dat_in[7:0];
      ist_q <= (ist_q & ~((wr_ok && wb_adr_in == `ESA_OFF_IRQ_STAT) ? wb_dat_in[7:0] : 8'h00)) | ch_pend;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      irq_out      <= 1'b0;
      irq_pin_out  <= 1'b0;
      irq_oe_b_out <= 1'b1;
      ser_pins_out <= {8{3'b100}};
    end else begin
      irq_out      <= (ist_q & imsk_q) != 8'h00;
      irq_pin_out  <= 1'b0;
      irq_oe_b_out <= (ist_q & imsk_q) == 8'h00;
      ser_pins_out <= ch_out;
    end
  end
endmodule

// file: verif/esa_adapter_checker.sv
// Bus and interrupt checks on the adapter's top ports.
`timescale 1ns/1ps
`include "esa_defs.svh"
module esa_adapter_checker
  import esa_pkg::*;
(
  input wire logic                clk_sys_in,
  input wire logic                rst_b_in,
  input wire logic                wb_cyc_in,
  input wire logic                wb_stb_in,
  input wire logic                wb_we_in,
  input wire logic [8:0]          wb_adr_in,
  input wire logic [31:0]         wb_dat_out,
  input wire logic                wb_ack_out,
  input wire esa_line_out_s [7:0] ser_pins_out,
  input wire logic                irq_out,
  input wire logic                irq_pin_out,
  input wire logic                irq_oe_b_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence req_s; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
  sequence ans_s; wb_ack_out ##1 !wb_ack_out; endsequence
  ack_next_a: assert property (req_s |=> ans_s) else $error("ack missing or long");
  ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  byte_lane_a: assert property (wb_ack_out && $past(!wb_we_in && wb_adr_in != 9'h130)
    |-> wb_dat_out[31:8] == 24'h0) else $error("read data wider than a byte");
  arb_width_a: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0) else $error("wide read");
  arb_type_a: assert property (wb_ack_out && $past(!wb_we_in && wb_adr_in == 9'h130) && wb_dat_out[15]
    |-> wb_dat_out[7:4] != `ESA_ID_NONE) else $error("pending winner without source");
  unmapped_a: assert property (wb_ack_out && $past(!wb_we_in && wb_adr_in[8:2] == 7'h4f)
    |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  pin_low_a: assert property (irq_pin_out == 1'b0) else $error("request pin data high");
  line_pull_a: assert property (irq_out |-> !irq_oe_b_out) else $error("line not pulled");
  tx_idle_a: assert property (disable iff (1'b0) !rst_b_in |=> ser_pins_out[0].tx && ser_pins_out[7].tx
    && !wb_ack_out && irq_oe_b_out) else $error("not idle in reset");
endmodule
bind esa_adapter esa_adapter_checker i_esa_adapter_checker (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .ser_pins_out(ser_pins_out), .irq_out(irq_out),
  .irq_pin_out(irq_pin_out), .irq_oe_b_out(irq_oe_b_out));

// file: verif/esa_term_model.sv
// Loopback plug standing in for the terminals on all eight ports.
`timescale 1ns/1ps
module esa_term_model
  import esa_pkg::*;
(
  input  wire esa_line_out_s [7:0] pins_in,
  output esa_line_in_s [7:0]       pins_out
);
  // Each port hears its own sender, so rx idles at mark exactly when tx does.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pins_out[i] = '{rx: pins_in[i].tx, cts: pins_in[i].rts, dsr: pins_in[i].dtr, ri: 1'b0, dcd: pins_in[i].dtr};
    end
  end
endmodule

// file: verif/esa_adapter_bench.sv
// Register-level bench for the serial adapter.
`timescale 1ns/1ps
`include "esa_defs.svh"
module esa_adapter_bench
  import esa_pkg::*;
;
  logic               clk_sys_in = 1'b0;
  logic               rst_b_in = 1'b0;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               we = 1'b0;
  logic [8:0]         adr = 9'h0;
  logic [31:0]        wdat = 32'h0;
  logic [31:0]        rdat;
  logic [31:0]        q;
  logic               ack;
  logic               irq;
  logic               oe_b;
  esa_line_in_s [7:0]  pins_i;
  esa_line_out_s [7:0] pins_o;
  int                 errors = 0;
  int                 num_checks = 0;
  initial forever #2 clk_sys_in = ~clk_sys_in;
  esa_adapter i_esa_adapter (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .ser_pins_in(pins_i), .wb_dat_out(rdat),
    .wb_ack_out(ack), .ser_pins_out(pins_o), .irq_out(irq), .irq_pin_out(), .irq_oe_b_out(oe_b));
  esa_term_model i_esa_term_model (.pins_in(pins_o), .pins_out(pins_i));
  function automatic logic [8:0] ra(input int c, input int r);
    return 9'(32 * c + 4 * r);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
    do @(posedge clk_sys_in); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    bus(0, ra(0, 3), 0); chk(q, 32'h3);
    bus(0, 9'h13c, 0); chk(q, 32'h0);
    for (int c = 0; c < 8; c++) bus(1, ra(c, 7), 8'(8'h30 + c));
    for (int c = 0; c < 8; c++) begin
      bus(0, ra(c, 7), 0); chk(q, 32'(32'h30 + c));
    end
    $display("test registers done");
    // Port 2 uses 8 bits with even parity, port 5 uses 7 bits with none.
    bus(1, 9'h138, 8'h24); bus(1, ra(2, 3), 8'h1b); bus(1, ra(5, 3), 8'h02);
    bus(1, ra(2, 1), 8'h01); bus(1, ra(5, 1), 8'h01);
    bus(1, ra(5, 0), 8'hd5); bus(1, ra(2, 0), 8'ha5);
    for (int c = 2; c < 6; c += 3) begin
      q = 32'h0;
      for (int i = 0; i < 4000 && q[0] !== 1'b1; i++) bus(0, ra(c, 5), 0);
      chk(32'(q[4:0]), 32'h1);
    end
    chk(32'(irq), 32'h1); chk(32'(oe_b), 32'h0);
    bus(0, 9'h130, 0); chk(q, {16'h0, 1'b1, 4'h0, `ESA_ADAPTER_ID, `ESA_ID_RD, 4'h2});
    bus(0, ra(2, 0), 0); chk(q, 32'ha5);
    bus(0, 9'h130, 0); chk(q, {16'h0, 1'b1, 4'h0, `ESA_ADAPTER_ID, `ESA_ID_RD, 4'h5});
    bus(0, ra(5, 0), 0); chk(q, 32'h55);
    bus(0, 9'h134, 0); chk(q, 32'h24);
    bus(1, 9'h134, 8'hff);
    repeat (3) @(posedge clk_sys_in);
    chk(32'(irq), 32'h0);
    $display("test loopback done");
    bus(0, ra(1, 6), 0); bus(1, ra(1, 4), 8'h03);
    repeat (8) @(posedge clk_sys_in);
    bus(0, ra(1, 6), 0); chk(q, 32'hbb);
    bus(0, ra(1, 6), 0); chk(q, 32'hb0);
    bus(1, ra(0, 3), 8'h83); bus(1, ra(0, 0), 8'h02);
    bus(0, ra(0, 0), 0); chk(q, 32'h02);
    bus(1, ra(0, 3), 8'h03); bus(1, ra(3, 3), 8'h43);
    for (int i = 0; i < 4000 && q[4] !== 1'b1; i++) bus(0, ra(3, 5), 0);
    chk(32'(q[4]), 32'h1);
    bus(1, ra(3, 3), 8'h03);
    $display("test modem and break done");
    end_of_test();
  end
endmodule
